// File: dv/dff_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// serial bus master model: frames and bytes, msb first, clock parked high between frames
module dff_i2c_master (
    input  wire logic clk,       // system clock
    input  wire logic sda,       // resolved data line
    output var  logic scl,       // serial clock
    output var  logic m_sda_oe_n // data enable, low while pulling low
);
    // a quarter bit of five cycles keeps every edge well clear of the input sync
    localparam int QTR = 5;

    initial begin
        scl        = 1'b1;
        m_sda_oe_n = 1'b1;
    end

    task automatic q(input int n);
        repeat (n * QTR) @(negedge clk);
    endtask

    // start condition; from a low clock it acts as a repeated start
    task automatic start();
        m_sda_oe_n = 1'b1;
        q(1);
        scl = 1'b1;
        q(2);
        m_sda_oe_n = 1'b0;
        q(2);
        scl = 1'b0;
        q(1);
    endtask

    // stop condition, data rises while the clock is high
    task automatic stop();
        m_sda_oe_n = 1'b0;
        q(1);
        scl = 1'b1;
        q(2);
        m_sda_oe_n = 1'b1;
        q(2);
    endtask

    // one bit: data moves mid low phase, sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        m_sda_oe_n = b;
        q(1);
        scl = 1'b1;
        q(1);
        r = sda;
        q(1);
        scl = 1'b0;
        q(1);
    endtask

    // eight data bits then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], rx[i]);
        end
        bitx(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

// File: dv/dff_status_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the status bank; short histories absorb the two-flop input delay
module dff_status_bank_chk (
    input wire logic       clk,            // system clock
    input wire logic       rstn,           // async reset, active low
    input wire logic       scl_in,         // serial clock pin
    input wire logic       sda_oe_n,       // serial data enable
    input wire logic [1:0] oc_now,         // overcurrent present
    input wire logic [1:0] oc_timeout,     // overcurrent timed out
    input wire logic [1:0] vlow_raw,       // output below level
    input wire logic [1:0] cable_raw,      // cable reads open
    input wire logic       overtemp_raw,   // overtemperature
    input wire logic       supply_low_raw, // supply low
    input wire logic [1:0] feed_output,    // feed enables
    input wire logic       irq             // fault request
);
    wire logic any_flt = (|oc_now) | (|oc_timeout) | (|vlow_raw) | (|cable_raw);
    wire logic hot_sup = overtemp_raw | supply_low_raw;
    logic [7:0] flt_hist_r;
    logic [5:0] trip1_hist_r;
    logic [5:0] trip2_hist_r;

    // recent causes; six to eight cycles cover sync, flag and output stages
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flt_hist_r   <= 8'h00;
            trip1_hist_r <= 6'h00;
            trip2_hist_r <= 6'h00;
        end else begin
            flt_hist_r   <= {flt_hist_r[6:0], any_flt | hot_sup};
            trip1_hist_r <= {trip1_hist_r[4:0], oc_timeout[0] | hot_sup};
            trip2_hist_r <= {trip2_hist_r[4:0], oc_timeout[1] | hot_sup};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("serial data moved while clock high");
    a_trip_ch1: assert property ($fell(feed_output[0]) |-> scl_in || trip1_hist_r != 6'h00)
        else $error("channel 1 output dropped without cause");
    a_trip_ch2: assert property ($fell(feed_output[1]) |-> scl_in || trip2_hist_r != 6'h00)
        else $error("channel 2 output dropped without cause");
    a_heat_off: assert property (overtemp_raw [*6] |-> feed_output == 2'h0)
        else $error("output on during overtemperature");
    a_supply_off: assert property (supply_low_raw [*6] |-> feed_output == 2'h0)
        else $error("output on during supply low");
    a_feed_on_write: assert property ($rose(feed_output[0]) || $rose(feed_output[1]) |-> scl_in)
        else $error("output switched on outside end of write");
    a_irq_cause: assert property ($rose(irq) |-> flt_hist_r != 8'h00)
        else $error("request raised without a fault input");
    a_sync_delay: assert property ($rose(overtemp_raw) && !irq |=> !irq)
        else $error("request reacted before input synchronisation");
endmodule

bind dff_status_bank dff_status_bank_chk i_chk (
    .clk, .rstn, .scl_in, .sda_oe_n, .oc_now, .oc_timeout, .vlow_raw,
    .cable_raw, .overtemp_raw, .supply_low_raw, .feed_output, .irq
);
`default_nettype wire

// File: dv/tb_dual_feed_fault_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
// status bank bench: the master model polls both status bytes around injected faults
module tb_dual_feed_fault_status_bank;
    logic       clk;
    logic       rstn;
    logic       ce;
    logic       scl;
    logic       m_sda_oe_n;
    logic       sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic [1:0] oc_now;
    logic [1:0] oc_timeout;
    logic [1:0] vlow_raw;
    logic [1:0] tone_raw;
    logic [1:0] cable_raw;
    logic       overtemp_raw;
    logic       supply_low_raw;
    logic [1:0] feed_output;
    logic [3:0] vsel_ch1;
    logic [3:0] vsel_ch2;
    logic [1:0] cable_test_on;
    logic [1:0] tone_mode;
    logic [1:0] tone_gate;
    logic       irq;
    logic [7:0] rdb [0:2];
    int         miscompares;
    int         num_checks;

    // open-drain data line with pull-up
    assign sda = (sda_oe_n | sda_out) & m_sda_oe_n;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    dff_status_bank i_dut (
        .clk, .rstn, .ce, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
        .oc_now, .oc_timeout, .vlow_raw, .tone_raw, .cable_raw, .overtemp_raw,
        .supply_low_raw, .feed_output, .vsel_ch1, .vsel_ch2, .tone_mode,
        .tone_gate, .cable_test_on, .irq
    );

    dff_i2c_master i_master (.clk, .sda, .scl, .m_sda_oe_n);

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    // read n bytes in one frame, last one not acknowledged
    task automatic rd(input int n);
        logic [7:0] junk;
        logic       a;
        i_master.start();
        i_master.xfer({dff_pkg::DEV_ADDR_DFLT, 1'b1}, 1'b1, junk, a);
        chk({7'h00, a}, 8'h00);
        for (int i = 0; i < n; i++) begin
            i_master.xfer(8'hff, i == n - 1, rdb[i], a);
        end
        i_master.stop();
        w(4);
    endtask

    // two control bytes in one write frame
    task automatic wr(input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] junk;
        logic       a;
        i_master.start();
        i_master.xfer({dff_pkg::DEV_ADDR_DFLT, 1'b0}, 1'b1, junk, a);
        i_master.xfer(b0, 1'b1, junk, a);
        i_master.xfer(b1, 1'b1, junk, a);
        chk({7'h00, a}, 8'h00);
        i_master.stop();
        w(4);
    endtask

    // power-on state, byte alternation, foreign address left unanswered
    task automatic s_power_on();
        logic [7:0] junk;
        logic       a;
        chk({7'h00, irq}, 8'h00);
        rd(3);
        chk(rdb[0], 8'h03);
        chk(rdb[1], 8'h00);
        chk(rdb[2], 8'h03);
        i_master.start();
        i_master.xfer({dff_pkg::DEV_ADDR_DFLT ^ 7'h01, 1'b1}, 1'b1, junk, a);
        i_master.stop();
        chk({7'h00, a}, 8'h01);
    endtask

    task automatic s_enable();
        wr(8'h35, 8'h7a);
        chk({6'h00, feed_output}, 8'h03);
        chk({vsel_ch2, vsel_ch1}, 8'ha5);
        rd(2);
        chk(rdb[0], 8'h00);
        chk(rdb[1], 8'h00);
    endtask

    // live flags follow their inputs; cable flag needs the test enabled
    task automatic s_live();
        wr(8'h87, 8'hc2);
        chk({2'h0, tone_mode, tone_gate, cable_test_on}, 8'h1d);
        vlow_raw  = 2'h1;
        tone_raw  = 2'h2;
        cable_raw = 2'h1;
        w(10);
        chk({7'h00, irq}, 8'h01);
        rd(2);
        chk(rdb[0], 8'h10);
        chk(rdb[1], 8'h09);
        vlow_raw = 2'h0;
        tone_raw = 2'h0;
        wr(8'h80, 8'hc0);
        chk({2'h0, tone_mode, tone_gate, cable_test_on}, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rd(2);
        chk(rdb[0], 8'h00);
        chk(rdb[1], 8'h00);
        cable_raw = 2'h0;
    endtask

    // timed overcurrent on channel 1 latches until the ninth read clock
    task automatic s_oc_timed();
        oc_now     = 2'h1;
        oc_timeout = 2'h1;
        w(10);
        chk({6'h00, feed_output}, 8'h02);
        oc_now     = 2'h0;
        oc_timeout = 2'h0;
        w(10);
        chk({7'h00, irq}, 8'h01);
        rd(3);
        chk(rdb[0], 8'h05);
        chk(rdb[2], 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(8'h35, 8'h35);
        chk({6'h00, feed_output}, 8'h03);
        rd(1);
        chk(rdb[0], 8'h00);
    endtask

    // channel 2 with the cutoff timer off stays in current limit
    task automatic s_oc_live();
        wr(8'h60, 8'h60);
        oc_now     = 2'h2;
        oc_timeout = 2'h2;
        w(10);
        chk({6'h00, feed_output}, 8'h03);
        rd(1);
        chk(rdb[0], 8'h08);
        oc_now     = 2'h0;
        oc_timeout = 2'h0;
        w(10);
        chk({7'h00, irq}, 8'h00);
        // clock enable low must freeze the live flag and the request
        ce     = 1'b0;
        oc_now = 2'h2;
        w(10);
        chk({7'h00, irq}, 8'h00);
        ce     = 1'b1;
        w(10);
        chk({7'h00, irq}, 8'h01);
        oc_now = 2'h0;
        w(10);
    endtask

    // overtemperature then supply low: both outputs trip, flag resampled on reads
    task automatic s_trip();
        logic [7:0] flag;
        for (int k = 0; k < 2; k++) begin
            flag           = (k == 0) ? 8'h40 : 8'h80;
            overtemp_raw   = (k == 0);
            supply_low_raw = (k == 1);
            w(10);
            chk({6'h00, feed_output}, 8'h00);
            rd(3);
            chk(rdb[2], flag | 8'h03);
            overtemp_raw   = 1'b0;
            supply_low_raw = 1'b0;
            w(10);
            rd(3);
            chk(rdb[0], flag | 8'h03);
            chk(rdb[2], 8'h03);
            chk({6'h00, feed_output}, 8'h00);
            wr(8'h35, 8'h7a);
            chk({6'h00, feed_output}, 8'h03);
        end
    endtask

    initial begin
        miscompares    = 0;
        num_checks     = 0;
        rstn           = 1'b0;
        ce             = 1'b1;
        oc_now         = 2'h0;
        oc_timeout     = 2'h0;
        vlow_raw       = 2'h0;
        tone_raw       = 2'h0;
        cable_raw      = 2'h0;
        overtemp_raw   = 1'b0;
        supply_low_raw = 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        w(6);
        s_power_on();
        s_enable();
        s_live();
        s_oc_timed();
        s_oc_live();
        s_trip();
        print_verdict();
    end

    // the sequence needs about 12k cycles; eight times that means a hang
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: logic/dff_pkg.sv
`default_nettype none
// shared constants for the dual feed fault status bank
package dff_pkg;
    // channel count of the regulator
    localparam int NCH = 2;

    // primary status byte layout (two-bit fields hold ch1 in the low bit)
    localparam int ST1_OFF  = 0;
    localparam int ST1_OC   = 2;
    localparam int ST1_VLOW = 4;
    localparam int ST1_OVH  = 6;
    localparam int ST1_SUP  = 7;

    // secondary status byte layout, bits 4..7 unused and read as zero
    localparam int ST2_CABLE = 0;
    localparam int ST2_TONE  = 2;
    localparam logic [3:0] ST2_UNUSED = 4'h0;

    // control byte layout: bits 7:6 select the target register
    localparam int CTL_VSEL_LSB = 0;
    localparam int CTL_VSEL_MSB = 3;
    localparam int CTL_TIMER    = 4;
    localparam int CTL_ON       = 5;
    localparam int CTL_SEL_LSB  = 6;
    localparam int CTL_SEL_MSB  = 7;
    localparam int AUX_MODE     = 0;
    localparam int AUX_GATE     = 1;
    localparam int AUX_CABLE    = 2;

    // reset values
    localparam logic [5:0] CTL_MAIN_RST = 6'h00;
    localparam logic [2:0] CTL_AUX_RST  = 3'h0;
    localparam logic [1:0] OFF_RST      = 2'h3;

    // bit counter marks within a byte on the serial link
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;

    // device address on the serial link, value is arbitrary
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h08;

    // positions inside the synchronised input vector
    localparam int SY_SCL   = 0;
    localparam int SY_SDA   = 1;
    localparam int SY_OCN   = 2;
    localparam int SY_OCT   = 4;
    localparam int SY_VLOW  = 6;
    localparam int SY_TONE  = 8;
    localparam int SY_CABLE = 10;
    localparam int SY_OVT   = 12;
    localparam int SY_SUP   = 13;
    localparam int SY_W     = 14;

    // serial link engine states
    typedef enum logic [1:0] {
        DFF_IDLE,
        DFF_ADDR,
        DFF_WR,
        DFF_RD
    } dff_state_t;
endpackage
`default_nettype wire

// File: logic/dff_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dff_status_bank #(
    parameter logic [6:0] DEV_ADDR = dff_pkg::DEV_ADDR_DFLT
) (
    input  wire logic       clk,            // 125 MHz system clock
    input  wire logic       rstn,           // async power-on reset, active low
    input  wire logic       ce,             // clock enable
    input  wire logic       scl_in,         // serial clock pin level
    input  wire logic       sda_in,         // serial data pin level
    output logic            sda_out,        // serial data drive value, always low
    output logic            sda_oe_n,       // serial data enable, low while driving
    input  wire logic [1:0] oc_now,         // overcurrent present per channel
    input  wire logic [1:0] oc_timeout,     // overcurrent beyond detection time
    input  wire logic [1:0] vlow_raw,       // output below programmed level
    input  wire logic [1:0] tone_raw,       // tone present at feed output
    input  wire logic [1:0] cable_raw,      // cable test reads open
    input  wire logic       overtemp_raw,   // die overtemperature
    input  wire logic       supply_low_raw, // input supply undervoltage
    output logic      [1:0] feed_output,    // feed output enable per channel
    output logic      [3:0] vsel_ch1,       // voltage select channel 1
    output logic      [3:0] vsel_ch2,       // voltage select channel 2
    output logic      [1:0] tone_mode,      // internal tone select per channel
    output logic      [1:0] tone_gate,      // tone gate per channel
    output logic      [1:0] cable_test_on,  // cable test enable per channel
    output logic            irq             // fault request, active high
);
    logic [dff_pkg::SY_W-1:0] raw;
    logic [dff_pkg::SY_W-1:0] syn;

    // every pin and analog level crosses two flops before use
    assign raw = {supply_low_raw, overtemp_raw, cable_raw, tone_raw, vlow_raw,
                  oc_timeout, oc_now, sda_in, scl_in};

    dff_sync #(.W(dff_pkg::SY_W)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .d    (raw),
        .q    (syn)
    );

    logic       scl;
    logic       sda;
    logic [1:0] ocn;
    logic [1:0] oct;
    logic [1:0] vlw;
    logic [1:0] tnr;
    logic [1:0] cbr;
    logic       ovt;
    logic       sup;

    assign scl = syn[dff_pkg::SY_SCL];
    assign sda = syn[dff_pkg::SY_SDA];
    assign ocn = syn[dff_pkg::SY_OCN +: 2];
    assign oct = syn[dff_pkg::SY_OCT +: 2];
    assign vlw = syn[dff_pkg::SY_VLOW +: 2];
    assign tnr = syn[dff_pkg::SY_TONE +: 2];
    assign cbr = syn[dff_pkg::SY_CABLE +: 2];
    assign ovt = syn[dff_pkg::SY_OVT];
    assign sup = syn[dff_pkg::SY_SUP];

    // address byte decode, used at the ack drive and at the ninth clock
    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:1] == DEV_ADDR);
    endfunction

    // ---------------- serial link engine ----------------
    dff_pkg::dff_state_t state_r, state_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic       drv_r, drv_nxt;
    logic       nine_r, nine_nxt;
    logic       ptr_r, ptr_nxt;
    logic       wrote_r, wrote_nxt;
    logic       scl_q_r, sda_q_r;
    logic [5:0] main_r [2];
    logic [5:0] main_nxt [2];
    logic [2:0] aux_r [2];
    logic [2:0] aux_nxt [2];
    logic       start;
    logic       stop;
    logic       scl_rise;
    logic       scl_fall;
    logic       read_tick;
    logic       write_end;
    logic [7:0] st1;
    logic [7:0] st2;

    // bus conditions from the synchronised levels and their last sample
    assign start    = scl & scl_q_r & sda_q_r & ~sda;
    assign stop     = scl & scl_q_r & ~sda_q_r & sda;
    assign scl_rise = scl & ~scl_q_r;
    assign scl_fall = ~scl & scl_q_r;

    // byte framing, ack drive, control capture and read data shifting
    always_comb begin
        logic [7:0] b;
        logic [7:0] ld;
        b          = {sh_r[6:0], sda};
        ld         = ptr_r ? st2 : st1;
        state_nxt  = state_r;
        bitcnt_nxt = bitcnt_r;
        sh_nxt     = sh_r;
        drv_nxt    = drv_r;
        nine_nxt   = nine_r;
        ptr_nxt    = ptr_r;
        wrote_nxt  = wrote_r;
        main_nxt   = main_r;
        aux_nxt    = aux_r;
        read_tick  = 1'b0;
        write_end  = 1'b0;
        if (start) begin
            // repeated start also closes a pending write sequence
            write_end  = wrote_r;
            state_nxt  = dff_pkg::DFF_ADDR;
            bitcnt_nxt = '0;
            drv_nxt    = 1'b0;
            nine_nxt   = 1'b0;
            ptr_nxt    = 1'b0;
            wrote_nxt  = 1'b0;
        end else if (stop) begin
            write_end  = wrote_r;
            state_nxt  = dff_pkg::DFF_IDLE;
            drv_nxt    = 1'b0;
            nine_nxt   = 1'b0;
            wrote_nxt  = 1'b0;
        end else if (state_r != dff_pkg::DFF_IDLE) begin
            if (scl_rise) begin
                if (bitcnt_r != dff_pkg::BIT_ACK) begin
                    bitcnt_nxt = bitcnt_r + 4'h1;
                    if (state_r != dff_pkg::DFF_RD) begin
                        sh_nxt = b;
                    end
                    if (state_r == dff_pkg::DFF_WR && bitcnt_r == dff_pkg::BIT_LAST) begin
                        wrote_nxt = 1'b1;
                        if (!b[dff_pkg::CTL_SEL_MSB]) begin
                            main_nxt[b[dff_pkg::CTL_SEL_LSB]] = b[5:0];
                        end else begin
                            aux_nxt[b[dff_pkg::CTL_SEL_LSB]] = b[2:0];
                        end
                    end
                end else begin
                    // ninth clock of the byte
                    bitcnt_nxt = '0;
                    nine_nxt   = 1'b1;
                    case (state_r)
                        dff_pkg::DFF_ADDR: begin
                            if (!addr_hit(sh_r)) begin
                                state_nxt = dff_pkg::DFF_IDLE;
                            end else if (sh_r[0]) begin
                                state_nxt = dff_pkg::DFF_RD;
                            end else begin
                                state_nxt = dff_pkg::DFF_WR;
                            end
                        end
                        dff_pkg::DFF_RD: begin
                            read_tick = 1'b1;
                            ptr_nxt   = ~ptr_r;
                            if (sda) begin
                                state_nxt = dff_pkg::DFF_IDLE;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (scl_fall) begin
                if (bitcnt_r == dff_pkg::BIT_ACK) begin
                    // ack our address or a control byte, free the line for master ack
                    drv_nxt = (state_r == dff_pkg::DFF_WR) ||
                              (state_r == dff_pkg::DFF_ADDR && addr_hit(sh_r));
                end else if (nine_r) begin
                    nine_nxt = 1'b0;
                    if (state_r == dff_pkg::DFF_RD) begin
                        sh_nxt  = ld;
                        drv_nxt = ~ld[7];
                    end else begin
                        drv_nxt = 1'b0;
                    end
                end else if (state_r == dff_pkg::DFF_RD) begin
                    sh_nxt  = {sh_r[6:0], 1'b0};
                    drv_nxt = ~sh_r[6];
                end
            end
        end
    end

    // link engine registers; pin history starts at the idle-high level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r  <= dff_pkg::DFF_IDLE;
            bitcnt_r <= '0;
            sh_r     <= '0;
            drv_r    <= 1'b0;
            nine_r   <= 1'b0;
            ptr_r    <= 1'b0;
            wrote_r  <= 1'b0;
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
            main_r   <= '{dff_pkg::CTL_MAIN_RST, dff_pkg::CTL_MAIN_RST};
            aux_r    <= '{dff_pkg::CTL_AUX_RST, dff_pkg::CTL_AUX_RST};
        end else if (ce) begin
            state_r  <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            sh_r     <= sh_nxt;
            drv_r    <= drv_nxt;
            nine_r   <= nine_nxt;
            ptr_r    <= ptr_nxt;
            wrote_r  <= wrote_nxt;
            scl_q_r  <= scl;
            sda_q_r  <= sda;
            main_r   <= main_nxt;
            aux_r    <= aux_nxt;
        end
    end

    // open-drain data: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drv_r;

    // ---------------- fault flags ----------------
    logic [1:0] feed_r, feed_nxt;
    logic [1:0] trip_r, trip_nxt;
    logic [1:0] off_r, off_nxt;
    logic [1:0] oc_r, oc_nxt;
    logic [1:0] vlow_r, vlow_nxt;
    logic [1:0] cab_r, cab_nxt;
    logic [1:0] tone_r, tone_nxt;
    logic       ovh_r, ovh_nxt;
    logic       sl_r, sl_nxt;
    logic       irq_r, irq_nxt;

    // a healthy part with feeds on shows all zeros in both bytes
    always_comb begin
        st1 = '0;
        st1[dff_pkg::ST1_OFF +: 2]  = off_r;
        st1[dff_pkg::ST1_OC +: 2]   = oc_r;
        st1[dff_pkg::ST1_VLOW +: 2] = vlow_r;
        st1[dff_pkg::ST1_OVH]       = ovh_r;
        st1[dff_pkg::ST1_SUP]       = sl_r;
        st2 = {dff_pkg::ST2_UNUSED, tone_r, cab_r};
    end

    // flag updates; an event in the same cycle as a read clear wins
    always_comb begin
        logic ten;
        logic hit;
        ten     = 1'b0;
        hit     = 1'b0;
        ovh_nxt = read_tick ? ovt : ovh_r;
        if (ovt) begin
            ovh_nxt = 1'b1;
        end
        sl_nxt = read_tick ? sup : sl_r;
        if (sup) begin
            sl_nxt = 1'b1;
        end
        trip_nxt = trip_r;
        feed_nxt = feed_r;
        off_nxt  = off_r;
        oc_nxt   = oc_r;
        vlow_nxt = vlow_r;
        cab_nxt  = cab_r;
        tone_nxt = tone_r;
        for (int i = 0; i < dff_pkg::NCH; i++) begin
            ten = main_r[i][dff_pkg::CTL_TIMER];
            hit = ten & oct[i] & feed_r[i];
            // trip holds until a write sequence ends with the causes gone
            trip_nxt[i] = trip_r[i] | hit | ovt | sup;
            if (write_end) begin
                trip_nxt[i] = hit | ovt | sup;
            end
            feed_nxt[i] = main_r[i][dff_pkg::CTL_ON] & ~trip_nxt[i];
            if (!ten) begin
                oc_nxt[i] = ocn[i];
            end else begin
                oc_nxt[i] = read_tick ? 1'b0 : oc_r[i];
                if (hit) begin
                    oc_nxt[i] = 1'b1;
                end
            end
            if (write_end && feed_nxt[i]) begin
                off_nxt[i] = 1'b0;
            end
            if (!feed_nxt[i]) begin
                off_nxt[i] = 1'b1;
            end
            vlow_nxt[i] = vlw[i] & feed_r[i];
            cab_nxt[i]  = cbr[i] & aux_r[i][dff_pkg::AUX_CABLE];
            tone_nxt[i] = tnr[i];
        end
        // output-off alone never raises the request
        irq_nxt = (|oc_nxt) | (|vlow_nxt) | (|cab_nxt) | ovh_nxt | sl_nxt;
    end

    // flags; output-off starts set since feeds are off at power-on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            feed_r <= '0;
            trip_r <= '0;
            off_r  <= dff_pkg::OFF_RST;
            oc_r   <= '0;
            vlow_r <= '0;
            cab_r  <= '0;
            tone_r <= '0;
            ovh_r  <= 1'b0;
            sl_r   <= 1'b0;
            irq_r  <= 1'b0;
        end else if (ce) begin
            feed_r <= feed_nxt;
            trip_r <= trip_nxt;
            off_r  <= off_nxt;
            oc_r   <= oc_nxt;
            vlow_r <= vlow_nxt;
            cab_r  <= cab_nxt;
            tone_r <= tone_nxt;
            ovh_r  <= ovh_nxt;
            sl_r   <= sl_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // control fields straight from their registers
    assign feed_output   = feed_r;
    assign irq           = irq_r;
    assign vsel_ch1      = main_r[0][dff_pkg::CTL_VSEL_MSB:dff_pkg::CTL_VSEL_LSB];
    assign vsel_ch2      = main_r[1][dff_pkg::CTL_VSEL_MSB:dff_pkg::CTL_VSEL_LSB];
    assign tone_mode     = {aux_r[1][dff_pkg::AUX_MODE], aux_r[0][dff_pkg::AUX_MODE]};
    assign tone_gate     = {aux_r[1][dff_pkg::AUX_GATE], aux_r[0][dff_pkg::AUX_GATE]};
    assign cable_test_on = {aux_r[1][dff_pkg::AUX_CABLE], aux_r[0][dff_pkg::AUX_CABLE]};
endmodule
`default_nettype wire

// File: logic/dff_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a vector of asynchronous levels
module dff_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,  // system clock
    input  wire logic         rstn, // async reset, active low
    input  wire logic         ce,   // clock enable, freezes state when low
    input  wire logic [W-1:0] d,    // asynchronous levels
    output logic      [W-1:0] q     // levels in the clk domain
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // first stage is read only by the second stage
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule
`default_nettype wire
